// ==== pkg/gptwd_pkg.sv ====
// Constants, types and register map for the timer and watchdog block.
// Assumes one system clock and a 16-bit word-addressed register port.
`default_nettype none
package gptwd_pkg;
	localparam int NT = 3;
	// Register word addresses
	localparam logic [15:0] TMR_BASE [NT] = '{16'h1810, 16'h1850, 16'h1890};
	localparam logic [15:0] OFS_CTRL = 16'h0000;
	localparam logic [15:0] OFS_PRD_LO = 16'h0002;
	localparam logic [15:0] OFS_PRD_HI = 16'h0003;
	localparam logic [15:0] OFS_CNT_LO = 16'h0004;
	localparam logic [15:0] OFS_CNT_HI = 16'h0005;
	localparam logic [15:0] OFS_INSEL = 16'h0006;
	localparam logic [15:0] ADR_FLAGS = 16'h18c0;
	localparam logic [15:0] ADR_ROUTE = 16'h18c2;
	localparam logic [15:0] ADR_WD_COUNT = 16'h18b0;
	// Lock registers, then the control register each one guards
	localparam logic [15:0] ADR_LOCK [4] = '{16'h1880, 16'h1884, 16'h1888, 16'h188c};
	localparam logic [15:0] ADR_WDCTL [4] = '{16'h18a0, 16'h18a4, 16'h18a8, 16'h18ac};
	localparam int LK_KICK = 0;
	localparam int LK_START = 1;
	localparam int LK_ENABLE = 2;
	localparam int LK_PSC = 3;
	localparam logic [15:0] WD_KEY [4][3] = '{
		'{16'h5555, 16'haaaa, 16'h0000},
		'{16'h6666, 16'h0bbb, 16'h0000},
		'{16'h7777, 16'hcccc, 16'hdddd},
		'{16'h5a5a, 16'ha5a5, 16'h0000}};
	localparam int WD_KEY_CNT [4] = '{2, 2, 3, 2};
	// Control register fields
	localparam int CTRL_EN = 15;
	localparam int CTRL_PSC_HI = 5;
	localparam int CTRL_PSC_LO = 2;
	localparam int CTRL_AUTO = 1;
	localparam int CTRL_START = 0;
	localparam int WD_EN_BIT = 0;
	// Reset values and counts
	localparam logic [31:0] PRD_RST = 32'hffff_ffff;
	localparam logic [31:0] CNT_RST = 32'hffff_ffff;
	localparam logic [3:0] PSC_MAX_CODE = 4'hc;
	localparam logic [2:0] SYNC_TICKS = 3'h4;
	localparam logic [2:0] INSEL_SYS = 3'h0;
	typedef enum logic [3:0] {
		LK_KEY0 = 4'b0001,
		LK_KEY1 = 4'b0010,
		LK_KEY2 = 4'b0100,
		LK_OPEN = 4'b1000
	} gptwd_lock_type;
	typedef struct packed {
		logic [15:0] addr;
		logic [15:0] wdata;
		logic wr;
		logic rd;
	} gptwd_bus_type;
endpackage
`default_nettype wire

// ==== hdl/gptwd_top.sv ====
// Three down-counting timers with prescalers, a watchdog on timer 2 guarded
// by key locks, and an expiry flag collector. Assumes clk at 200 MHz, rst
// synchronous, and external source clocks that are slow against clk.
// Summary of operation
// - Every timer owns a 13-bit prescaler dividing its chosen source clock.
// - Counter and period are 32 bits, seen as low and high 16-bit words.
// - Start bit 1 copies period into counter, then counts down per prescaled tick.
// - Counter reaching zero sets that timer's collector flag and raises a request.
// - Route select picks maskable irq plus four DMA events, or the NMI.
// - Auto repeat reloads the period at zero and keeps counting.
// - First expiry after start lands 4 or 5 source cycles late.
// - Each timer picks its source: system clock, USB oscillator, PLL input or pin.
// - Only timer 2 has the watchdog: 16-bit counter after 16-bit prescaler.
// - Watchdog exhaustion requests a chip reset, real-time clock excluded.
// - After reset the watchdog stays disabled until software enables it.
// - A watchdog control register takes one write after its keys, then relocks.
// - A wrong key sends that lock back to waiting for the first key.
// - Each lock has its own state machine, so key writes may interleave.
// - Unlocked enable register bit 0 enables, or disables, the watchdog.
// - Unlocked kick write starts or restarts the watchdog from its start value.
// - Hardware reset returns every timer register and the flags to defaults.
// - Flags latch expiries, OR into one interrupt, clear by writing one.
// - Prescale code 0000 divides by 2 up to code 1100 dividing by 8192.
// - Start write while counting restarts; start reads 1 while counting.
// - Timer enable gates prescaler and counter; clear means neither counts.
`default_nettype none
module gptwd_top #(
	parameter int NUM_GPIO = 5
) (
	input wire logic clk,
	input wire logic rst,
	input wire gptwd_pkg::gptwd_bus_type bus,
	input wire logic usb_osc_clk,
	input wire logic pll_in_clk,
	input wire logic [NUM_GPIO-1:0] gpio_clk,
	output logic [15:0] rdata_q,
	output logic maskable_timer_irq,
	output logic nmi_q,
	output logic [3:0] dma_event_q,
	output logic chip_reset_q
);
	localparam int NP = NUM_GPIO + 2;
	logic [NP-1:0] pin_raw;
	logic [NP-1:0] s1_q;
	logic [NP-1:0] s2_q;
	logic [NP-1:0] s3_q;
	logic [7:0] tick_vec;
	logic [2:0] exp_v;
	logic [2:0] run_v;
	logic [2:0] flag_q;
	logic [2:0] route_q;
	logic [2:0] rh;
	logic [15:0] rv [3];
	logic [3:0] lk_open;
	logic [3:0] ctl_ok;
	logic wd_en_q;
	logic wd_run_q;
	logic [15:0] wd_start_q;
	logic [15:0] wd_psc_q;
	logic [15:0] wd_cnt_q;
	logic [15:0] wd_pcnt_q;
	logic wd_expire;
	logic [15:0] rd_d;
	logic irq_d;

	assign pin_raw = {pll_in_clk, usb_osc_clk, gpio_clk};

	// Three-stage pin synchroniser, edge taken from stages two and three
	always_ff @(posedge clk) begin
		if (rst) begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
		end else begin
			s1_q <= pin_raw;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	// Source tick per select code: 0 system, 1..5 pins, 6 USB, 7 PLL input
	always_comb begin
		tick_vec = 8'h00;
		tick_vec[0] = 1'b1;
		for (int i = 0; i < NP; i++) begin
			tick_vec[i + 1] = s2_q[i] & ~s3_q[i];
		end
	end

	genvar t;
	generate
		for (t = 0; t < gptwd_pkg::NT; t++) begin : g_tmr
			localparam logic [15:0] B = gptwd_pkg::TMR_BASE[t];
			logic en_q;
			logic auto_q;
			logic run_q;
			logic pend_q;
			logic [3:0] psel_q;
			logic [2:0] insel_q;
			logic [2:0] sync_q;
			logic [12:0] psc_q;
			logic [31:0] prd_q;
			logic [31:0] cnt_q;
			logic [3:0] code;
			logic [13:0] lim;
			logic src_tick;
			logic main_tick;
			logic load;
			logic wr_ctrl;
			logic start_w;
			assign wr_ctrl = bus.wr && bus.addr == B + gptwd_pkg::OFS_CTRL;
			assign start_w = wr_ctrl && bus.wdata[gptwd_pkg::CTRL_START];
			assign src_tick = tick_vec[insel_q];
			assign code = (psel_q > gptwd_pkg::PSC_MAX_CODE) ? gptwd_pkg::PSC_MAX_CODE : psel_q;
			assign lim = (14'h0001 << (code + 4'h1)) - 14'h0001;
			assign main_tick = en_q && src_tick && psc_q == lim[12:0];
			assign load = pend_q && src_tick && sync_q == gptwd_pkg::SYNC_TICKS - 3'h1;
			assign exp_v[t] = run_q && !load && main_tick && cnt_q <= 32'h0000_0001;
			assign run_v[t] = run_q;

			// Control and input select
			always_ff @(posedge clk) begin
				if (rst) begin
					en_q <= 1'b0;
					psel_q <= 4'h0;
					auto_q <= 1'b0;
					insel_q <= gptwd_pkg::INSEL_SYS;
				end else if (wr_ctrl) begin
					en_q <= bus.wdata[gptwd_pkg::CTRL_EN];
					psel_q <= bus.wdata[gptwd_pkg::CTRL_PSC_HI:gptwd_pkg::CTRL_PSC_LO];
					auto_q <= bus.wdata[gptwd_pkg::CTRL_AUTO];
				end else if (bus.wr && bus.addr == B + gptwd_pkg::OFS_INSEL) begin
					insel_q <= bus.wdata[2:0];
				end
			end

			// Period words
			always_ff @(posedge clk) begin
				if (rst) begin
					prd_q <= gptwd_pkg::PRD_RST;
				end else if (bus.wr && bus.addr == B + gptwd_pkg::OFS_PRD_LO) begin
					prd_q[15:0] <= bus.wdata;
				end else if (bus.wr && bus.addr == B + gptwd_pkg::OFS_PRD_HI) begin
					prd_q[31:16] <= bus.wdata;
				end
			end

			// Start request held until the source clock has carried it across
			always_ff @(posedge clk) begin
				if (rst) begin
					pend_q <= 1'b0;
					sync_q <= 3'h0;
				end else if (start_w) begin
					pend_q <= 1'b1;
					sync_q <= 3'h0;
				end else if (load) begin
					pend_q <= 1'b0;
				end else if (pend_q && src_tick) begin
					sync_q <= sync_q + 3'h1;
				end
			end

			// Prescaler
			always_ff @(posedge clk) begin
				if (rst || load) begin
					psc_q <= 13'h0000;
				end else if (en_q && src_tick) begin
					psc_q <= main_tick ? 13'h0000 : psc_q + 13'h0001;
				end
			end

			// Main counter
			always_ff @(posedge clk) begin
				if (rst) begin
					cnt_q <= gptwd_pkg::CNT_RST;
					run_q <= 1'b0;
				end else if (load) begin
					cnt_q <= prd_q;
					run_q <= 1'b1;
				end else if (bus.wr && bus.addr == B + gptwd_pkg::OFS_CNT_LO) begin
					cnt_q[15:0] <= bus.wdata;
				end else if (bus.wr && bus.addr == B + gptwd_pkg::OFS_CNT_HI) begin
					cnt_q[31:16] <= bus.wdata;
				end else if (exp_v[t]) begin
					cnt_q <= auto_q ? prd_q : 32'h0000_0000;
					run_q <= auto_q;
				end else if (run_q && main_tick) begin
					cnt_q <= cnt_q - 32'h0000_0001;
				end
			end

			// Read view of this timer
			always_comb begin
				rh[t] = 1'b1;
				rv[t] = 16'h0000;
				if (bus.addr == B + gptwd_pkg::OFS_CTRL) begin
					rv[t] = {en_q, 9'h000, psel_q, auto_q, run_q | pend_q};
				end else if (bus.addr == B + gptwd_pkg::OFS_PRD_LO) begin
					rv[t] = prd_q[15:0];
				end else if (bus.addr == B + gptwd_pkg::OFS_PRD_HI) begin
					rv[t] = prd_q[31:16];
				end else if (bus.addr == B + gptwd_pkg::OFS_CNT_LO) begin
					rv[t] = cnt_q[15:0];
				end else if (bus.addr == B + gptwd_pkg::OFS_CNT_HI) begin
					rv[t] = cnt_q[31:16];
				end else if (bus.addr == B + gptwd_pkg::OFS_INSEL) begin
					rv[t] = {13'h0000, insel_q};
				end else begin
					rh[t] = 1'b0;
				end
			end
		end
	endgenerate

	// Expiry flag collector, set wins over a write-one clear
	always_ff @(posedge clk) begin
		if (rst) begin
			flag_q <= 3'h0;
		end else if (bus.wr && bus.addr == gptwd_pkg::ADR_FLAGS) begin
			flag_q <= (flag_q & ~bus.wdata[2:0]) | exp_v;
		end else begin
			flag_q <= flag_q | exp_v;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			route_q <= 3'h0;
		end else if (bus.wr && bus.addr == gptwd_pkg::ADR_ROUTE) begin
			route_q <= bus.wdata[2:0];
		end
	end

	// Interrupt and DMA event outputs
	assign irq_d = |(flag_q & ~route_q);
	always_ff @(posedge clk) begin
		if (rst) begin
			maskable_timer_irq <= 1'b0;
			nmi_q <= 1'b0;
			dma_event_q <= 4'h0;
		end else begin
			maskable_timer_irq <= irq_d;
			nmi_q <= |(flag_q & route_q);
			dma_event_q <= {4{|(exp_v & ~route_q)}};
		end
	end

	// Key locks, one state machine each
	genvar k;
	generate
		for (k = 0; k < 4; k++) begin : g_lock
			gptwd_pkg::gptwd_lock_type st_q;
			logic wr_lock;
			logic wr_ctl;
			assign wr_lock = bus.wr && bus.addr == gptwd_pkg::ADR_LOCK[k];
			assign wr_ctl = bus.wr && bus.addr == gptwd_pkg::ADR_WDCTL[k];
			assign lk_open[k] = st_q == gptwd_pkg::LK_OPEN;
			assign ctl_ok[k] = wr_ctl && lk_open[k];
			always_ff @(posedge clk) begin
				if (rst) begin
					st_q <= gptwd_pkg::LK_KEY0;
				end else if (wr_lock) begin
					case (st_q)
						gptwd_pkg::LK_KEY1: begin
							if (bus.wdata != gptwd_pkg::WD_KEY[k][1]) begin
								st_q <= gptwd_pkg::LK_KEY0;
							end else if (gptwd_pkg::WD_KEY_CNT[k] == 2) begin
								st_q <= gptwd_pkg::LK_OPEN;
							end else begin
								st_q <= gptwd_pkg::LK_KEY2;
							end
						end
						gptwd_pkg::LK_KEY2: begin
							st_q <= (bus.wdata == gptwd_pkg::WD_KEY[k][2]) ?
								gptwd_pkg::LK_OPEN : gptwd_pkg::LK_KEY0;
						end
						default: begin
							st_q <= (bus.wdata == gptwd_pkg::WD_KEY[k][0]) ?
								gptwd_pkg::LK_KEY1 : gptwd_pkg::LK_KEY0;
						end
					endcase
				end else if (ctl_ok[k]) begin
					st_q <= gptwd_pkg::LK_KEY0;
				end
			end
		end
	endgenerate

	// Watchdog configuration
	always_ff @(posedge clk) begin
		if (rst) begin
			wd_en_q <= 1'b0;
			wd_start_q <= 16'hffff;
			wd_psc_q <= 16'hffff;
		end else begin
			if (ctl_ok[gptwd_pkg::LK_ENABLE]) begin
				wd_en_q <= bus.wdata[gptwd_pkg::WD_EN_BIT];
			end
			if (ctl_ok[gptwd_pkg::LK_START]) begin
				wd_start_q <= bus.wdata;
			end
			if (ctl_ok[gptwd_pkg::LK_PSC]) begin
				wd_psc_q <= bus.wdata;
			end
		end
	end

	// Watchdog countdown on the system clock
	assign wd_expire = wd_en_q && wd_run_q && wd_cnt_q == 16'h0000 && wd_pcnt_q == 16'h0000;
	always_ff @(posedge clk) begin
		if (rst) begin
			wd_run_q <= 1'b0;
			wd_cnt_q <= 16'hffff;
			wd_pcnt_q <= 16'hffff;
		end else if (ctl_ok[gptwd_pkg::LK_KICK]) begin
			wd_run_q <= 1'b1;
			wd_cnt_q <= wd_start_q;
			wd_pcnt_q <= wd_psc_q;
		end else if (wd_expire) begin
			wd_run_q <= 1'b0;
		end else if (wd_en_q && wd_run_q) begin
			if (wd_pcnt_q == 16'h0000) begin
				wd_pcnt_q <= wd_psc_q;
				wd_cnt_q <= wd_cnt_q - 16'h0001;
			end else begin
				wd_pcnt_q <= wd_pcnt_q - 16'h0001;
			end
		end
	end

	// Chip reset request, held until the chip reset returns
	always_ff @(posedge clk) begin
		if (rst) begin
			chip_reset_q <= 1'b0;
		end else if (wd_expire) begin
			chip_reset_q <= 1'b1;
		end
	end

	// Read port, data one cycle after the strobe
	always_comb begin
		rd_d = 16'h0000;
		if (rh[0]) begin
			rd_d = rv[0];
		end else if (rh[1]) begin
			rd_d = rv[1];
		end else if (rh[2]) begin
			rd_d = rv[2];
		end else if (bus.addr == gptwd_pkg::ADR_FLAGS) begin
			rd_d = {13'h0000, flag_q};
		end else if (bus.addr == gptwd_pkg::ADR_ROUTE) begin
			rd_d = {13'h0000, route_q};
		end else if (bus.addr == gptwd_pkg::ADR_WDCTL[gptwd_pkg::LK_ENABLE]) begin
			rd_d = {15'h0000, wd_en_q};
		end else if (bus.addr == gptwd_pkg::ADR_WDCTL[gptwd_pkg::LK_START]) begin
			rd_d = wd_start_q;
		end else if (bus.addr == gptwd_pkg::ADR_WDCTL[gptwd_pkg::LK_PSC]) begin
			rd_d = wd_psc_q;
		end else if (bus.addr == gptwd_pkg::ADR_WD_COUNT) begin
			rd_d = wd_cnt_q;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			rdata_q <= 16'h0000;
		end else if (bus.rd) begin
			rdata_q <= rd_d;
		end else begin
			rdata_q <= 16'h0000;
		end
	end

	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	sequence s_start0;
		g_tmr[0].start_w && g_tmr[0].insel_q == 3'h0
		##1 (!g_tmr[0].start_w && g_tmr[0].insel_q == 3'h0) [*4];
	endsequence

	sequence s_keys_kick;
		g_lock[0].wr_lock && bus.wdata == 16'h5555 && g_lock[0].st_q == gptwd_pkg::LK_KEY0
		##1 g_lock[0].wr_lock && bus.wdata == 16'haaaa;
	endsequence

	chk_first_start: assert property (s_start0 |=> run_v[0])
		else $error("timer 0 did not start four source ticks after start");
	chk_flag_set: assert property (exp_v != 3'h0 |=> (flag_q & $past(exp_v)) == $past(exp_v))
		else $error("expiry did not set its flag");
	chk_flag_hold: assert property (flag_q[0] && !(bus.wr && bus.addr == gptwd_pkg::ADR_FLAGS
		&& bus.wdata[0]) |=> flag_q[0])
		else $error("flag cleared without a write of one");
	chk_irq_or: assert property (|(flag_q & ~route_q) |=> maskable_timer_irq)
		else $error("maskable irq missing for a set flag");
	chk_kick_unlock: assert property (s_keys_kick |=> lk_open[0])
		else $error("kick lock did not open after its keys");
	chk_lock_relock: assert property (ctl_ok != 4'h0 |=> (lk_open & $past(ctl_ok)) == 4'h0)
		else $error("lock stayed open after a control write");
	chk_bad_key: assert property (g_lock[0].wr_lock && g_lock[0].st_q == gptwd_pkg::LK_KEY1
		&& bus.wdata != 16'haaaa |=> g_lock[0].st_q == gptwd_pkg::LK_KEY0)
		else $error("wrong key did not restart the lock");
	chk_wd_off: assert property (!wd_en_q && !ctl_ok[gptwd_pkg::LK_ENABLE] |=> !wd_en_q)
		else $error("watchdog enabled without an unlocked write");
	chk_wd_reset: assert property (wd_expire |=> chip_reset_q)
		else $error("watchdog expiry did not request chip reset");
	chk_auto_reload: assert property (exp_v[0] && g_tmr[0].auto_q && !bus.wr
		|=> g_tmr[0].cnt_q == $past(g_tmr[0].prd_q) && run_v[0])
		else $error("auto repeat did not reload the period");
endmodule
`default_nettype wire

// ==== sim/gptwd_irq_sink.sv ====
// Far-side model: CPU NMI input and the four DMA event inputs.
// Assumes the block's outputs are registered on clk.
`default_nettype none
module gptwd_irq_sink (
	input wire logic clk,
	input wire logic rst,
	input wire logic nmi_q,
	input wire logic [3:0] dma_event_q,
	output int dma_cnt,
	output int nmi_cnt,
	output logic dma_split
);
	timeunit 1ns;
	timeprecision 1ps;
	logic nmi_d1;
	// Counts events and notes any DMA controller left out
	always @(posedge clk) begin
		if (rst) begin
			dma_cnt <= 0;
			nmi_cnt <= 0;
			dma_split <= 1'b0;
			nmi_d1 <= 1'b0;
		end else begin
			nmi_d1 <= nmi_q;
			if (dma_event_q === 4'hf) dma_cnt <= dma_cnt + 1;
			if (dma_event_q !== 4'hf && dma_event_q !== 4'h0) dma_split <= 1'b1;
			if (nmi_q === 1'b1 && nmi_d1 === 1'b0) nmi_cnt <= nmi_cnt + 1;
		end
	end
endmodule
`default_nettype wire

// ==== sim/gptwd_tb_top.sv ====
// Self-checking bench for the timer and watchdog block.
// Assumes 200 MHz clk, synchronous active-high rst, slow free-running source clocks.
`default_nettype none
module gptwd_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [15:0] t0b = gptwd_pkg::TMR_BASE[0];
	localparam logic [15:0] t1b = gptwd_pkg::TMR_BASE[1];
	localparam logic [15:0] t2b = gptwd_pkg::TMR_BASE[2];
	localparam logic [15:0] flg = gptwd_pkg::ADR_FLAGS;
	logic clk = 1'b0;
	logic rst = 1'b1;
	gptwd_pkg::gptwd_bus_type bus = '0;
	logic usb_clk = 1'b0;
	logic pll_clk = 1'b0;
	logic [4:0] gpio_clk = 5'h00;
	logic [15:0] rdata_q;
	logic irq;
	logic nmi;
	logic chip_rst;
	logic [3:0] dma;
	int dma_cnt;
	int nmi_cnt;
	logic dma_split;
	int error_cnt = 0;
	int total_checks = 0;
	int t0;
	int t1;
	int n;
	logic [15:0] srcs [3] = '{16'h0001, 16'h0006, 16'h0007};

	always #2.5 clk = ~clk;
	always #20 usb_clk = ~usb_clk;
	always #35 pll_clk = ~pll_clk;
	always #45 gpio_clk = ~gpio_clk;

	gptwd_top #(.NUM_GPIO(5)) i_dut (.clk(clk), .rst(rst), .bus(bus), .usb_osc_clk(usb_clk),
		.pll_in_clk(pll_clk), .gpio_clk(gpio_clk), .rdata_q(rdata_q),
		.maskable_timer_irq(irq), .nmi_q(nmi), .dma_event_q(dma), .chip_reset_q(chip_rst));
	gptwd_irq_sink i_sink (.clk(clk), .rst(rst), .nmi_q(nmi), .dma_event_q(dma),
		.dma_cnt(dma_cnt), .nmi_cnt(nmi_cnt), .dma_split(dma_split));

	task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		@(posedge clk);
		bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk);
		bus.wr <= 1'b0;
	endtask
	task automatic rchk(input string name, input logic [15:0] a, input logic [15:0] exp);
		@(posedge clk);
		bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
		@(posedge clk);
		bus.rd <= 1'b0;
		#1;
		chk(name, rdata_q, exp);
	endtask
	// Bounded wait on irq (0), nmi (1) or chip reset (2)
	task automatic wait_hi(input int which, input int lim, output int cyc);
		cyc = 0;
		while (cyc < lim && (which == 0 ? irq : which == 1 ? nmi : chip_rst) !== 1'b1) begin
			@(posedge clk);
			#1 cyc++;
		end
	endtask
	task automatic unlock(input int i);
		for (int k = 0; k < gptwd_pkg::WD_KEY_CNT[i]; k++) begin
			wr(gptwd_pkg::ADR_LOCK[i], gptwd_pkg::WD_KEY[i][k]);
		end
	endtask
	task automatic close_out();
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	initial begin
		#100us;
		error_cnt++;
		close_out();
	end

	initial begin
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		rchk("prd_lo", t0b + 16'h0002, 16'hffff);
		rchk("cnt_hi", t1b + 16'h0005, 16'hffff);
		rchk("ctrl", t2b, 16'h0000);
		rchk("flags", flg, 16'h0000);
		rchk("unmapped", 16'h1900, 16'h0000);
		// One-shot timer 0, then the same with divide by 8
		wr(t0b + 16'h0002, 16'h0003);
		wr(t0b + 16'h0003, 16'h0000);
		wr(t0b, 16'h8001);
		wait_hi(0, 400, t0);
		chk("irq0", {15'h0, irq}, 16'h0001);
		chk("dma0", 16'(dma_cnt), 16'h0001);
		rchk("flag0", flg, 16'h0001);
		rchk("stopped", t0b, 16'h8000);
		wr(flg, 16'h0001);
		rchk("cleared", flg, 16'h0000);
		chk("irq_off", {15'h0, irq}, 16'h0000);
		wr(t0b, 16'h8009);
		wait_hi(0, 400, t1);
		chk("div_step", 16'(t1 - t0 >= 17 && t1 - t0 <= 19), 16'h0001);
		// Auto repeat keeps expiring
		wr(flg, 16'h0007);
		n = dma_cnt;
		wr(t0b, 16'h8003);
		rchk("running", t0b, 16'h8003);
		repeat (60) @(posedge clk);
		chk("reloads", 16'(dma_cnt - n >= 4), 16'h0001);
		wr(t0b, 16'h0000);
		repeat (20) @(posedge clk);
		wr(flg, 16'h0007);
		// Timer 1 without enable must not count
		n = dma_cnt;
		wr(t1b + 16'h0002, 16'h0005);
		wr(t1b + 16'h0003, 16'h0000);
		wr(t1b, 16'h0001);
		repeat (40) @(posedge clk);
		rchk("gated", flg, 16'h0000);
		// Timer 1 routed to the NMI
		wr(gptwd_pkg::ADR_ROUTE, 16'h0002);
		wr(t1b, 16'h8001);
		wait_hi(1, 200, t0);
		repeat (2) @(posedge clk);
		chk("nmi", 16'(nmi_cnt), 16'h0001);
		chk("no_irq", {15'h0, irq}, 16'h0000);
		chk("no_dma", 16'(dma_cnt - n), 16'h0000);
		rchk("flag1", flg, 16'h0002);
		wr(flg, 16'h0002);
		wr(gptwd_pkg::ADR_ROUTE, 16'h0000);
		// Timer 2 on the slow sources
		wr(t2b + 16'h0002, 16'h0002);
		wr(t2b + 16'h0003, 16'h0000);
		foreach (srcs[i]) begin
			wr(t2b + 16'h0006, srcs[i]);
			wr(t2b, 16'h8001);
			wait_hi(0, 400, n);
			chk("slow_src", 16'(n > 40 && irq === 1'b1), 16'h0001);
			wr(flg, 16'h0004);
		end
		chk("dma_all", {15'h0, dma_split}, 16'h0000);
		// Watchdog keys interleaved across two locks
		wr(gptwd_pkg::ADR_LOCK[1], 16'h6666);
		wr(gptwd_pkg::ADR_LOCK[3], 16'h5a5a);
		wr(gptwd_pkg::ADR_LOCK[1], gptwd_pkg::WD_KEY[1][1]);
		wr(gptwd_pkg::ADR_LOCK[3], 16'ha5a5);
		wr(gptwd_pkg::ADR_WDCTL[1], 16'h0010);
		wr(gptwd_pkg::ADR_WDCTL[3], 16'h0003);
		wr(gptwd_pkg::ADR_WDCTL[1], 16'h0002);
		unlock(gptwd_pkg::LK_ENABLE);
		wr(gptwd_pkg::ADR_WDCTL[2], 16'h0001);
		wr(gptwd_pkg::ADR_LOCK[0], 16'h5555);
		wr(gptwd_pkg::ADR_LOCK[0], 16'h1234);
		wr(gptwd_pkg::ADR_LOCK[0], 16'haaaa);
		wr(gptwd_pkg::ADR_WDCTL[0], 16'h0000);
		wait_hi(2, 200, n);
		chk("unkicked", {15'h0, chip_rst}, 16'h0000);
		unlock(gptwd_pkg::LK_KICK);
		wr(gptwd_pkg::ADR_WDCTL[0], 16'h0000);
		rchk("wd_load", gptwd_pkg::ADR_WD_COUNT, 16'h0010);
		wait_hi(2, 300, n);
		chk("wd_fire", 16'(n >= 50 && n <= 80), 16'h0001);
		repeat (10) @(posedge clk);
		chk("wd_hold", {15'h0, chip_rst}, 16'h0001);
		// Second reset leaves the watchdog off
		rst <= 1'b1;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		#1;
		chk("rst_out", {15'h0, chip_rst}, 16'h0000);
		unlock(gptwd_pkg::LK_KICK);
		wr(gptwd_pkg::ADR_WDCTL[0], 16'h0000);
		wait_hi(2, 200, n);
		chk("wd_off", {15'h0, chip_rst}, 16'h0000);
		rchk("flags2", flg, 16'h0000);
		close_out();
	end
endmodule
`default_nettype wire
